// file: hw/csp_rate_gen.sv
// Rate generator: divides the processor clock into the bit clock
`timescale 1ns/1ps
`default_nettype none
module csp_rate_gen
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Generator side
  csp_rg_if.gen rg
);
  logic [7:0] cnt_q;
  logic lvl_q;
  logic wrap;
  // Each half period lasts div+1 input clocks
  assign wrap = (cnt_q == rg.div);
  assign rg.rise = rg.run && wrap && !lvl_q;
  assign rg.fall = rg.run && wrap && lvl_q;
  assign rg.level = lvl_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rg.run)
      cnt_q <= 8'h00; // Held in reset until released
    else if (wrap)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rg.run)
      lvl_q <= 1'b0;
    else if (wrap)
      lvl_q <= !lvl_q;
  end
endmodule // csp_rate_gen
`default_nettype wire

// file: hw/csp_serial_port.sv
// Clock-stop serial port: SPI master with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module csp_serial_port
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial pins
  output logic tx_bit_clock,
  output logic tx_frame_sync,
  output logic serial_out_pin,
  input wire logic serial_in_pin,
  // Events
  output logic rx_irq,
  output logic tx_irq
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01,
    ST_DONE = 2'b11} csp_state_t;

  logic [15:0] pc1_q, pc2_q, pin_q, rxf1_q, rxf2_q, txf1_q, txf2_q;
  logic [15:0] rg1_q, rg2_q, wd_q;
  logic [7:0] txh_q, rxh_q, tsr_q, rsr_q, awa_q;
  logic [3:0] bit_q;
  logic [1:0] rr_q, br_q;
  logic [31:0] rd_q;
  logic rx_rdy_q, tx_rdy_q, ovr_q, dout_q, fs_q, clk_q;
  logic aw_q, w_q, bv_q, rv_q;
  csp_state_t st_q;
  logic din, do_write, rd_take, rx_en, tx_en, spi_mode, word_done;
  logic rx_launch, tx_launch, rx_sample;

  csp_rg_if rg ();

  csp_rate_gen u_gen
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .rg(rg)
  );

  csp_sync u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(serial_in_pin),
    .level(din)
  );

  function automatic logic [15:0] merge(input logic [15:0] old,
    input logic [31:0] d, input logic [3:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic map_ok(input logic [7:0] a);
    case (a)
      csp_pkg::OFF_RX_HOLD, csp_pkg::OFF_TX_HOLD, csp_pkg::OFF_PIN,
      csp_pkg::OFF_PCTL_ONE, csp_pkg::OFF_PCTL_TWO, csp_pkg::OFF_RXF_ONE,
      csp_pkg::OFF_RXF_TWO, csp_pkg::OFF_TXF_ONE, csp_pkg::OFF_TXF_TWO,
      csp_pkg::OFF_RG_ONE, csp_pkg::OFF_RG_TWO: map_ok = 1'b1;
      default: map_ok = 1'b0;
    endcase
  endfunction

  // Generator only runs from processor clock when selected
  assign rg.run = pc2_q[csp_pkg::P2_GEN_EN] && rg2_q[csp_pkg::RG2_CLKSM];
  assign rg.div = rg1_q[7:0];
  assign rx_en = pc1_q[csp_pkg::P1_RX_EN] && !pin_q[csp_pkg::PIN_RX_GPIO];
  assign tx_en = pc2_q[csp_pkg::P2_TX_EN];
  assign spi_mode = pc1_q[12:11] == csp_pkg::CSTP_SPI;
  // Pin clock is the word-gated level XOR polarity, so a level rise is always the launch
  // edge; the sample edge is picked by both polarity bits
  assign tx_launch = rg.rise;
  assign rx_sample = (pin_q[csp_pkg::PIN_RX_POL] ^ pin_q[csp_pkg::PIN_TX_POL])
    ? rg.rise : rg.fall;
  assign rx_launch = st_q == ST_IDLE && !tx_rdy_q && tx_en && spi_mode;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign do_write = aw_q && w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 16'h0000;
      bv_q <= 1'b0;
      br_q <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q <= 1'b1;
        wd_q <= merge(16'h0000, s_axi_wdata, s_axi_wstrb);
      end
      if (do_write)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= map_ok(awa_q) ? 2'b00 : 2'b10;
      end
      else if (bv_q && s_axi_bready)
        bv_q <= 1'b0;
    end
  end

  // Byte strobes are folded in at the data beat; unwritten lanes keep zero
  // which is acceptable since software writes whole halfwords here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc1_q <= csp_pkg::RST_ZERO;
      pc2_q <= csp_pkg::RST_ZERO;
      pin_q <= csp_pkg::RST_ZERO;
      rxf1_q <= csp_pkg::RST_ZERO;
      rxf2_q <= csp_pkg::RST_ZERO;
      txf1_q <= csp_pkg::RST_ZERO;
      txf2_q <= csp_pkg::RST_ZERO;
      rg1_q <= csp_pkg::RST_RG_ONE;
      rg2_q <= csp_pkg::RST_RG_TWO;
    end
    else if (do_write)
    begin
      case (awa_q)
        csp_pkg::OFF_PCTL_ONE: pc1_q <= wd_q;
        csp_pkg::OFF_PCTL_TWO: pc2_q <= wd_q;
        csp_pkg::OFF_PIN: pin_q <= wd_q;
        csp_pkg::OFF_RXF_ONE: rxf1_q <= wd_q;
        csp_pkg::OFF_RXF_TWO: rxf2_q <= wd_q;
        csp_pkg::OFF_TXF_ONE: txf1_q <= wd_q;
        csp_pkg::OFF_TXF_TWO: txf2_q <= wd_q;
        csp_pkg::OFF_RG_ONE: rg1_q <= wd_q;
        csp_pkg::OFF_RG_TWO: rg2_q <= wd_q;
        default: ;
      endcase
    end
  end

  // Transmit holding word; a write marks it full
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      txh_q <= 8'h00;
    else if (do_write && awa_q == csp_pkg::OFF_TX_HOLD)
      txh_q <= wd_q[7:0]; // 8-bit words only use the low byte
  end

  // Transmit ready: set when loaded into shifter, set wins over write
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_en)
      tx_rdy_q <= 1'b1;
    else if (rx_launch && tx_launch)
      tx_rdy_q <= 1'b1;
    else if (do_write && awa_q == csp_pkg::OFF_TX_HOLD)
      tx_rdy_q <= 1'b0; // Dummy write starts a receive too
  end

  // Shift engine: one single-phase 8-bit word per frame
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_en)
    begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      tsr_q <= 8'h00;
      dout_q <= 1'b0;
      fs_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (rx_launch && tx_launch)
          begin
            // First bit goes out with frame sync, no delay
            tsr_q <= {txh_q[6:0], 1'b0};
            dout_q <= txh_q[7]; // MSB first, no companding
            fs_q <= pin_q[csp_pkg::PIN_FSX_M];
            bit_q <= 4'h1;
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tx_launch)
          begin
            if (bit_q == csp_pkg::WORD_BITS[3:0])
            begin
              fs_q <= 1'b0;
              st_q <= ST_DONE;
            end
            else
            begin
              dout_q <= tsr_q[7];
              tsr_q <= {tsr_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Receive shifter samples the input on the chosen edge
  assign word_done = st_q == ST_SHIFT && rx_sample &&
    bit_q == csp_pkg::WORD_BITS[3:0];
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_en)
      rsr_q <= 8'h00;
    else if (st_q == ST_SHIFT && rx_sample)
      rsr_q <= {rsr_q[6:0], din};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rxh_q <= 8'h00;
    else if (rx_en && word_done)
      rxh_q <= {rsr_q[6:0], din};
  end

  // Word-waiting flag: new word wins over the clearing read
  assign rd_take = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_en)
    begin
      rx_rdy_q <= 1'b0;
      ovr_q <= 1'b0;
    end
    else if (word_done)
    begin
      rx_rdy_q <= 1'b1;
      ovr_q <= ovr_q || rx_rdy_q;
    end
    else if (rd_take && s_axi_araddr == csp_pkg::OFF_RX_HOLD)
      rx_rdy_q <= 1'b0;
  end

  // Clock idles low outside words in clock-stop mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_en)
      clk_q <= 1'b0;
    else if (tx_launch)
      clk_q <= pin_q[csp_pkg::PIN_TX_BIT_CLOCK_M] && (rx_launch ||
        (st_q == ST_SHIFT && bit_q != csp_pkg::WORD_BITS[3:0]));
    else if (rg.fall)
      clk_q <= 1'b0;
  end

  assign tx_bit_clock = clk_q ^ pin_q[csp_pkg::PIN_TX_POL];
  assign tx_frame_sync = fs_q ^ pin_q[csp_pkg::PIN_FSX_POL];
  assign serial_out_pin = dout_q;
  assign rx_irq = rx_rdy_q && pc1_q[5:4] == csp_pkg::RINTM_RDY;
  assign tx_irq = tx_rdy_q && tx_en;

  // Read channel
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
    end
    else if (rd_take)
    begin
      rv_q <= 1'b1;
      rr_q <= map_ok(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        csp_pkg::OFF_RX_HOLD: rd_q <= {24'h00_0000, rxh_q};
        csp_pkg::OFF_TX_HOLD: rd_q <= {24'h00_0000, txh_q};
        csp_pkg::OFF_PCTL_ONE:
          rd_q <= {16'h0000, pc1_q[15:3], ovr_q, rx_rdy_q, pc1_q[0]};
        csp_pkg::OFF_PCTL_TWO:
          rd_q <= {16'h0000, pc2_q[15:2], tx_rdy_q, pc2_q[0]};
        // Input level shown in GPIO mode
        csp_pkg::OFF_PIN:
          rd_q <= {16'h0000, pin_q[15:6], serial_out_pin, din, pin_q[3:0]};
        csp_pkg::OFF_RXF_ONE: rd_q <= {16'h0000, rxf1_q};
        csp_pkg::OFF_RXF_TWO: rd_q <= {16'h0000, rxf2_q};
        csp_pkg::OFF_TXF_ONE: rd_q <= {16'h0000, txf1_q};
        csp_pkg::OFF_TXF_TWO: rd_q <= {16'h0000, txf2_q};
        csp_pkg::OFF_RG_ONE: rd_q <= {16'h0000, rg1_q};
        csp_pkg::OFF_RG_TWO: rd_q <= {16'h0000, rg2_q};
        default: rd_q <= 32'h0000_0000;
      endcase
    end
    else if (rv_q && s_axi_rready)
      rv_q <= 1'b0;
  end
endmodule // csp_serial_port
`default_nettype wire

// file: hw/csp_sync.sv
// Three-stage input synchroniser with second/third agreement
`timescale 1ns/1ps
`default_nettype none
module csp_sync
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and result
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Only counts a change once two stages agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lvl_q <= 1'b0;
    else if (s2_q == s3_q)
      lvl_q <= s3_q;
  end
  assign level = lvl_q;
endmodule // csp_sync
`default_nettype wire

// file: pkg/csp_pkg.sv
// Package: register map, field positions and reset values of the serial port
package csp_pkg;
  // Register word indices; the byte address is four times the index
  localparam logic [7:0] IDX_RX_HOLD = 8'h02;
  localparam logic [7:0] IDX_TX_HOLD = 8'h06;
  localparam logic [7:0] IDX_PCTL_TWO = 8'h08;
  localparam logic [7:0] IDX_PCTL_ONE = 8'h0A;
  localparam logic [7:0] IDX_RXF_TWO = 8'h0C;
  localparam logic [7:0] IDX_RXF_ONE = 8'h0E;
  localparam logic [7:0] IDX_TXF_TWO = 8'h10;
  localparam logic [7:0] IDX_TXF_ONE = 8'h12;
  localparam logic [7:0] IDX_RG_TWO = 8'h14;
  localparam logic [7:0] IDX_RG_ONE = 8'h16;
  localparam logic [7:0] IDX_PIN = 8'h24;
  // Byte addresses on the bus (16-bit data in low bits)
  localparam logic [7:0] OFF_RX_HOLD = {IDX_RX_HOLD[5:0], 2'b00};
  localparam logic [7:0] OFF_TX_HOLD = {IDX_TX_HOLD[5:0], 2'b00};
  localparam logic [7:0] OFF_PCTL_TWO = {IDX_PCTL_TWO[5:0], 2'b00};
  localparam logic [7:0] OFF_PCTL_ONE = {IDX_PCTL_ONE[5:0], 2'b00};
  localparam logic [7:0] OFF_RXF_TWO = {IDX_RXF_TWO[5:0], 2'b00};
  localparam logic [7:0] OFF_RXF_ONE = {IDX_RXF_ONE[5:0], 2'b00};
  localparam logic [7:0] OFF_TXF_TWO = {IDX_TXF_TWO[5:0], 2'b00};
  localparam logic [7:0] OFF_TXF_ONE = {IDX_TXF_ONE[5:0], 2'b00};
  localparam logic [7:0] OFF_RG_TWO = {IDX_RG_TWO[5:0], 2'b00};
  localparam logic [7:0] OFF_RG_ONE = {IDX_RG_ONE[5:0], 2'b00};
  localparam logic [7:0] OFF_PIN = {IDX_PIN[5:0], 2'b00};
  // Field positions
  localparam int P1_RX_EN = 0;
  localparam int P1_RX_RDY = 1;
  localparam int P1_OVR = 2;
  localparam int P1_RINTM_LO = 4;
  localparam int P1_CSTP_LO = 11;
  localparam int P2_TX_EN = 0;
  localparam int P2_TX_RDY = 1;
  localparam int P2_GEN_EN = 6;
  localparam int PIN_RX_POL = 0;
  localparam int PIN_TX_POL = 1;
  localparam int PIN_FSX_POL = 3;
  localparam int PIN_IN_LVL = 4;
  localparam int PIN_OUT_LVL = 5;
  localparam int PIN_RX_BIT_CLOCK_M = 8;
  localparam int PIN_TX_BIT_CLOCK_M = 9;
  localparam int PIN_FSR_M = 10;
  localparam int PIN_FSX_M = 11;
  localparam int PIN_RX_GPIO = 12;
  localparam int F1_WLEN_LO = 5;
  localparam int F1_FLEN_LO = 8;
  localparam int F2_PHASE = 15;
  localparam int F2_COMP_LO = 3;
  localparam int F2_DLY_LO = 0;
  localparam int RG2_FRAME_SYNC_GEN_MODE = 12;
  localparam int RG2_CLKSM = 13;
  // Encodings
  localparam logic [1:0] CSTP_SPI = 2'b10;
  localparam logic [1:0] RINTM_RDY = 2'b00;
  localparam logic [2:0] WLEN_8 = 3'b000;
  localparam logic [1:0] COMP_NONE = 2'b00;
  localparam logic [1:0] DLY_ZERO = 2'b00;
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_RG_ONE = 16'h0001;
  localparam logic [15:0] RST_RG_TWO = 16'h2000;
  localparam logic [7:0] WORD_BITS = 8'h08;
endpackage

// file: pkg/csp_rg_if.sv
// Interface: rate generator tick and bit clock towards the shifter
`timescale 1ns/1ps
`default_nettype none
interface csp_rg_if;
  logic run;
  logic [7:0] div;
  logic rise;
  logic fall;
  logic level;
  modport gen (input run, input div, output rise, output fall, output level);
  modport use_side (output run, output div, input rise, input fall,
    input level);
endinterface // csp_rg_if
`default_nettype wire

// file: verif/csp_serial_port_asserts.sv
// Checker: port-level properties of the clock-stop serial port
`timescale 1ns/1ps
`default_nettype none
module csp_serial_port_asserts
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Serial pins and events
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic serial_out_pin,
  input wire logic rx_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Rising bit-clock edges counted inside the running frame
  logic clk_q;
  logic fs_q;
  logic rise;
  logic [3:0] cnt_q;
  assign rise = tx_bit_clock & ~clk_q & fs_q;
  always_ff @(posedge aclk)
  begin
    clk_q <= tx_bit_clock;
    fs_q <= tx_frame_sync;
  end
  always_ff @(posedge aclk)
  begin
    if (tx_frame_sync & ~fs_q)
      cnt_q <= 4'h0;
    else if (rise)
      cnt_q <= cnt_q + 4'h1;
  end
  AST_FRAME_BITS: assert property (
    (fs_q && !tx_frame_sync) |-> (cnt_q + {3'b000, rise}) == 4'h8)
    else $error("frame did not carry eight bit clocks");
  AST_SYNC_WITH_LAUNCH: assert property (
    $rose(tx_frame_sync) |-> $fell(tx_bit_clock))
    else $error("frame sync not aligned with first launch edge");
  AST_DATA_HOLD: assert property (
    (tx_frame_sync && $rose(tx_bit_clock)) |-> $stable(serial_out_pin))
    else $error("serial data moved on the sampling edge");
  AST_READ_LAT: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WRITE_LAT: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after request");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  AST_AW_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  AST_RESET_QUIET: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !rx_irq
      && !tx_frame_sync)
    else $error("outputs active after reset");
endmodule // csp_serial_port_asserts
bind csp_serial_port csp_serial_port_asserts u_asserts (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .tx_bit_clock, .tx_frame_sync, .serial_out_pin, .rx_irq);
`default_nettype wire

// file: verif/csp_spi_slave_model.sv
// Partner model: serial audio chip acting as clock-stop slave
`timescale 1ns/1ps
`default_nettype none
module csp_spi_slave_model
(
  // Serial pins
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic serial_out_pin,
  output logic serial_in_pin,
  // Bench side
  input wire logic [7:0] reply,
  input wire logic hold_en,
  input wire logic hold_lvl,
  output logic [7:0] got
);
  logic [7:0] sh;
  logic [3:0] n;
  logic last;
  initial
  begin
    sh = 8'h00;
    n = 4'h0;
    last = 1'b0;
    got = 8'h00;
  end
  always @(posedge tx_frame_sync)
  begin
    sh = reply;
    n = 4'h0;
  end
  // Capture on rising edges, MSB first
  always @(posedge tx_bit_clock)
    if (tx_frame_sync)
    begin
      got = {got[6:0], serial_out_pin};
      n = n + 4'h1;
    end
  always @(negedge tx_bit_clock)
    if (tx_frame_sync && n != 4'h0)
      sh = sh << 1;
  always @(negedge tx_frame_sync)
    last = sh[7];
  // Deselected line is not left at its last value, so stale bits show up
  assign serial_in_pin = hold_en ? hold_lvl : (tx_frame_sync ? sh[7] : ~last);
endmodule // csp_spi_slave_model
`default_nettype wire

// file: verif/test_clock_stop_serial_port.sv
// Testbench: register and serial transfer checks of the serial port
`timescale 1ns/1ps
`default_nettype none
module test_clock_stop_serial_port;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, tx_bit_clock;
  logic tx_frame_sync, serial_out_pin, serial_in_pin, rx_irq, tx_irq;
  logic hold_en, hold_lvl;
  logic [7:0] s_axi_awaddr, s_axi_araddr, reply, got;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] tx_tab [3] = '{16'h00A5, 16'h003C, 16'hFFFF};
  logic [7:0] rx_tab [3] = '{8'h5A, 8'hC3, 8'h81};
  int fails = 0;
  int samples_checked = 0;
  csp_serial_port dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_bit_clock,
    .tx_frame_sync, .serial_out_pin, .serial_in_pin, .rx_irq, .tx_irq);
  csp_spi_slave_model u_chip (.tx_bit_clock, .tx_frame_sync,
    .serial_out_pin, .serial_in_pin, .reply, .hold_en, .hold_lvl, .got);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic ad, wd, bd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    bd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !bd; n++)
    begin
      @(posedge aclk);
      if (!ad && s_axi_awready)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid)
      begin
        bd = 1'b1;
        s_axi_bready <= 1'b0;
        cmp(32'(s_axi_bresp), 32'(er));
      end
    end
    if (!bd)
      fails++;
    @(posedge aclk); // Idle edge: the next call never reassigns a strobe
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m, input logic [1:0] er);
    logic ad, bd;
    int n;
    ad = 1'b0;
    bd = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !bd; n++)
    begin
      @(posedge aclk);
      if (!ad && s_axi_arready)
      begin
        ad = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid)
      begin
        bd = 1'b1;
        s_axi_rready <= 1'b0;
        cmp(s_axi_rdata & m, e);
        cmp(32'(s_axi_rresp), 32'(er));
      end
    end
    if (!bd)
      fails++;
    @(posedge aclk); // Idle edge: the next call never reassigns a strobe
  endtask
  // Send one word and collect the chip's answer
  task automatic xfer(input logic [15:0] w, input logic [7:0] r);
    int n;
    reply = r;
    wr(csp_pkg::OFF_TX_HOLD, {16'h0000, w}, 2'b00);
    for (n = 0; n < 3000 && rx_irq !== 1'b1; n++)
      @(posedge aclk);
    cmp(32'(rx_irq), 32'h0000_0001);
    cmp(32'(got), 32'(w[7:0]));
    rd(csp_pkg::OFF_RX_HOLD, 32'(r), 32'h0000_00FF, 2'b00);
    repeat (2) @(posedge aclk);
    cmp(32'(rx_irq), 32'h0000_0000);
    cmp(32'(tx_bit_clock), 32'h0000_0001);
  endtask
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, hold_en, hold_lvl} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, reply} = 24'h00_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(csp_pkg::OFF_RG_ONE, 32'h0000_0001, 32'h0000_FFFF, 2'b00);
    rd(csp_pkg::OFF_RG_TWO, 32'h0000_2000, 32'h0000_FFFF, 2'b00);
    rd(csp_pkg::OFF_PCTL_ONE, 32'h0, 32'h0000_FFFF, 2'b00);
    rd(8'h04, 32'h0, 32'hFFFF_FFFF, 2'b10);
    wr(8'h04, 32'h0000_1234, 2'b10);
    cmp(32'(tx_irq), 32'h0000_0000);
    wr(csp_pkg::OFF_PCTL_ONE, 32'h0000_1000, 2'b00);
    wr(csp_pkg::OFF_PIN, 32'h0000_0A03, 2'b00);
    wr(csp_pkg::OFF_RXF_ONE, 32'h0, 2'b00);
    wr(csp_pkg::OFF_RXF_TWO, 32'h0, 2'b00);
    wr(csp_pkg::OFF_TXF_ONE, 32'h0, 2'b00);
    wr(csp_pkg::OFF_TXF_TWO, 32'h0, 2'b00);
    wr(csp_pkg::OFF_RG_ONE, 32'h0000_0007, 2'b00);
    wr(csp_pkg::OFF_RG_TWO, 32'h0000_2000, 2'b00);
    repeat (2) @(posedge aclk);
    wr(csp_pkg::OFF_PCTL_TWO, 32'h0000_0040, 2'b00);
    wr(csp_pkg::OFF_PCTL_ONE, 32'h0000_1001, 2'b00);
    wr(csp_pkg::OFF_PCTL_TWO, 32'h0000_0041, 2'b00);
    repeat (32) @(posedge aclk);
    cmp(32'(tx_irq), 32'h0000_0001);
    for (int i = 0; i < 3; i++)
      xfer(tx_tab[i], rx_tab[i]);
    // Receiver back in reset: a word on the wire must not raise rx_irq
    wr(csp_pkg::OFF_PCTL_ONE, 32'h0000_1000, 2'b00);
    wr(csp_pkg::OFF_TX_HOLD, 32'h0000_0066, 2'b00);
    repeat (300) @(posedge aclk);
    cmp(32'(rx_irq), 32'h0000_0000);
    wr(csp_pkg::OFF_PIN, 32'h0000_1A03, 2'b00);
    hold_en <= 1'b1;
    for (int l = 0; l < 2; l++)
    begin
      hold_lvl <= l[0];
      repeat (6) @(posedge aclk);
      rd(csp_pkg::OFF_PIN, 32'h0000_1A03 | (32'(l) << 4), 32'h0000_FFDF,
        2'b00);
    end
    close_out;
  end
  initial
  begin
    repeat (30000) @(posedge aclk);
    fails++;
    close_out;
  end
endmodule // test_clock_stop_serial_port
`default_nettype wire
